// ---- core/sctp_top.sv ----
// scan test port, emulator lines, output-off and branch-poll logic
`timescale 1ns/1ps
`default_nettype none

module sctp_top
#(
	parameter int GPIO_W = sctp_pkg::GPIO_W
)
(
	// clock and reset
	input  wire logic              REF_CLK,
	input  wire logic              SYS_RST,
	// test port pins
	input  wire logic              TCK,
	input  wire logic              TDI,
	input  wire logic              TMS,
	input  wire logic              SECOND_MODE_SELECT,
	input  wire logic              TRST,
	output logic                   TDO,
	output logic                   TDO_OE,
	// emulator line zero
	input  wire logic              EMULATOR_LINE_ZERO_IN,
	output logic                   EMULATOR_LINE_ZERO_OUT,
	output logic                   EMULATOR_LINE_ZERO_OE,
	// emulator line one, or output disable when low
	input  wire logic              EMULATOR_LINE_ONE_OR_DISABLE_IN,
	output logic                   EMULATOR_LINE_ONE_OR_DISABLE_OUT,
	output logic                   EMULATOR_LINE_ONE_OR_DISABLE_OE,
	// emulation interrupts to and from the core
	input  wire logic              EMU_IRQ0_TO_EMU,
	input  wire logic              EMU_IRQ1_TO_EMU,
	output logic                   EMU_IRQ0_FROM_EMU,
	output logic                   EMU_IRQ1_FROM_EMU,
	output logic                   SCAN_CONTROL,
	// global output disable for every pad driver
	output logic                   ALL_OUTPUTS_OFF,
	// general purpose port, bit one shared with branch poll
	input  wire logic [GPIO_W-1:0] GPIO_IN,
	input  wire logic [GPIO_W-1:0] GPIO_DIR_WR,
	input  wire logic              GPIO_DIR_WE,
	input  wire logic              PORT_C_BIT_ONE_AS_GPIO,
	input  wire logic              PORT_C_BIT_ONE_SEL_WE,
	output logic [GPIO_W-1:0]      GPIO_DIR,
	output logic                   PORT_C_BIT_ONE_IS_GPIO,
	// branch poll from the core
	input  wire logic              CONDITIONAL_BRANCH_OP,
	output logic                   BRANCH_TAKEN
);

	if (GPIO_W <= sctp_pkg::GPIO_BRANCH)
	begin : g_bad_width
		$error("GPIO_W too small for the shared branch pin");
	end

	// ****************************************
	// input synchronisers
	// ****************************************
	localparam int NSYNC = 8;
	logic [NSYNC-1:0] sync_a;
	logic [NSYNC-1:0] sync_b;
	logic             tck_d;
	logic             s_tck, s_tdi, s_tms, s_second_mode_select, s_trst, s_emulator_line_zero, s_emu1, s_bio;

	// each sampled pin passes two flops; the second stage is read, plus a third flop on the test clock for edges
	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
		begin
			// reset to the pulled levels so no false test clock edge or poll follows reset
			sync_a <= sctp_pkg::PIN_IDLE;
			sync_b <= sctp_pkg::PIN_IDLE;
			tck_d  <= sctp_pkg::PIN_IDLE[0];
		end
		else
		begin
			sync_a <= {GPIO_IN[sctp_pkg::GPIO_BRANCH], EMULATOR_LINE_ONE_OR_DISABLE_IN, EMULATOR_LINE_ZERO_IN,
				TRST, SECOND_MODE_SELECT, TMS, TDI, TCK};
			sync_b <= sync_a;
			tck_d  <= sync_b[0];
		end
	end

	assign {s_bio, s_emu1, s_emulator_line_zero, s_trst, s_second_mode_select, s_tms, s_tdi, s_tck} = sync_b;

	logic tck_rise;
	logic tck_fall;
	assign tck_rise = s_tck & ~tck_d;
	assign tck_fall = ~s_tck & tck_d;

	// ****************************************
	// tap controller
	// ****************************************
	logic tap_rst;
	logic st_reset, st_cap_dr, st_sh_dr, st_upd_dr, st_cap_ir, st_sh_ir, st_upd_ir;

	// test logic is held in reset while the scan system does not own the device
	assign tap_rst = SYS_RST | ~s_trst;

	sctp_tap_fsm u_fsm
	(
		.clk           (REF_CLK),
		.rst           (tap_rst),
		.tck_rise      (tck_rise),
		.tms           (s_tms),
		.second_mode_select          (s_second_mode_select),
		.st_reset      (st_reset),
		.st_capture_dr (st_cap_dr),
		.st_shift_dr   (st_sh_dr),
		.st_update_dr  (st_upd_dr),
		.st_capture_ir (st_cap_ir),
		.st_shift_ir   (st_sh_ir),
		.st_update_ir  (st_upd_ir)
	);

	// ****************************************
	// instruction and data registers
	// ****************************************
	logic [sctp_pkg::IR_WIDTH-1:0]   ir_shift;
	logic [sctp_pkg::IR_WIDTH-1:0]   ir;
	logic [31:0]                     id_shift;
	logic                            byp;
	logic [sctp_pkg::EMU_CTRL_W-1:0] ec_shift;
	logic [sctp_pkg::EMU_CTRL_W-1:0] emu_ctrl;
	logic                            sel_id, sel_ec;
	logic                            scan_out;

	assign sel_id = (ir == sctp_pkg::IR_IDCODE);
	assign sel_ec = (ir == sctp_pkg::IR_EMU_CTRL);
	assign scan_out = st_sh_ir ? ir_shift[0] :
		sel_id ? id_shift[0] :
		sel_ec ? ec_shift[0] : byp;

	always_ff @(posedge REF_CLK)
	begin
		if (tap_rst)
		begin
			ir_shift <= 4'h0;
			ir       <= sctp_pkg::IR_RESET_VAL;
			id_shift <= 32'h00000000;
			byp      <= 1'b0;
			ec_shift <= 4'h0;
			emu_ctrl <= sctp_pkg::EMU_CTRL_RST;
		end
		else if (tck_rise)
		begin
			if (st_cap_ir)
				ir_shift <= sctp_pkg::IR_CAPTURE;
			else if (st_sh_ir)
				ir_shift <= {s_tdi, ir_shift[sctp_pkg::IR_WIDTH-1:1]};
			if (st_upd_ir)
				ir <= ir_shift;
			else if (st_reset)
				ir <= sctp_pkg::IR_RESET_VAL;
			if (st_cap_dr)
			begin
				id_shift <= sctp_pkg::ID_VALUE;
				byp      <= 1'b0;
				ec_shift <= emu_ctrl;
			end
			else if (st_sh_dr)
			begin
				id_shift <= {s_tdi, id_shift[31:1]};
				byp      <= s_tdi;
				if (sel_ec)
					ec_shift <= {s_tdi, ec_shift[sctp_pkg::EMU_CTRL_W-1:1]};
			end
			if (st_upd_dr && sel_ec)
				emu_ctrl <= ec_shift;
		end
	end

	// output changes on falling test clock, enabled only while shifting
	always_ff @(posedge REF_CLK)
	begin
		if (tap_rst)
		begin
			TDO    <= 1'b0;
			TDO_OE <= 1'b0;
		end
		else if (tck_fall)
		begin
			TDO    <= scan_out;
			TDO_OE <= st_sh_ir | st_sh_dr;
		end
	end

	// ****************************************
	// emulator lines and output off
	// ****************************************
	// scan owns the device only while test reset is high
	assign SCAN_CONTROL = s_trst;

	// pad controls are registered so a glitch on a core request never reaches a pin
	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
		begin
			EMULATOR_LINE_ZERO_OE            <= 1'b0;
			EMULATOR_LINE_ZERO_OUT           <= 1'b0;
			EMULATOR_LINE_ONE_OR_DISABLE_OE  <= 1'b0;
			EMULATOR_LINE_ONE_OR_DISABLE_OUT <= 1'b0;
		end
		else
		begin
			EMULATOR_LINE_ZERO_OE            <= s_trst & emu_ctrl[sctp_pkg::EC_OE0];
			EMULATOR_LINE_ZERO_OUT           <= emu_ctrl[sctp_pkg::EC_OUT0] | EMU_IRQ0_TO_EMU;
			EMULATOR_LINE_ONE_OR_DISABLE_OE  <= s_trst & emu_ctrl[sctp_pkg::EC_OE1];
			EMULATOR_LINE_ONE_OR_DISABLE_OUT <= emu_ctrl[sctp_pkg::EC_OUT1] | EMU_IRQ1_TO_EMU;
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
		begin
			EMU_IRQ0_FROM_EMU <= 1'b0;
			EMU_IRQ1_FROM_EMU <= 1'b0;
			ALL_OUTPUTS_OFF   <= 1'b0;
		end
		else
		begin
			EMU_IRQ0_FROM_EMU <= s_trst & ~emu_ctrl[sctp_pkg::EC_OE0] & s_emulator_line_zero;
			EMU_IRQ1_FROM_EMU <= s_trst & ~emu_ctrl[sctp_pkg::EC_OE1] & s_emu1;
			// not meant as a bus-sharing release; synchronised so it lags the pins
			ALL_OUTPUTS_OFF   <= ~s_trst & s_emulator_line_zero & ~s_emu1;
		end
	end

	// ****************************************
	// gpio direction and branch poll
	// ****************************************
	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
		begin
			GPIO_DIR               <= '0;
			PORT_C_BIT_ONE_IS_GPIO <= 1'b0;
		end
		else
		begin
			if (GPIO_DIR_WE)
				GPIO_DIR <= GPIO_DIR_WR;
			if (PORT_C_BIT_ONE_SEL_WE)
				PORT_C_BIT_ONE_IS_GPIO <= PORT_C_BIT_ONE_AS_GPIO;
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
			BRANCH_TAKEN <= 1'b0;
		else
			BRANCH_TAKEN <= CONDITIONAL_BRANCH_OP & ~PORT_C_BIT_ONE_IS_GPIO & ~s_bio;
	end

endmodule
`default_nettype wire

// ---- core/sctp_pkg.sv ----
// package of constants for the scan port and output-off block
package sctp_pkg;

	// ********************************
	// tap instructions
	// ********************************
	localparam int          IR_WIDTH      = 4;
	localparam logic [3:0]  IR_BYPASS     = 4'hf;
	localparam logic [3:0]  IR_IDCODE     = 4'h1;
	localparam logic [3:0]  IR_EMU_CTRL   = 4'h8;
	localparam logic [3:0]  IR_RESET_VAL  = 4'h1;
	localparam logic [3:0]  IR_CAPTURE    = 4'h1;

	// ********************************
	// data registers
	// ********************************
	localparam int          EMU_CTRL_W    = 4;
	// emulation control fields: line drive enables and line output values
	localparam int          EC_OE0        = 0;
	localparam int          EC_OE1        = 1;
	localparam int          EC_OUT0       = 2;
	localparam int          EC_OUT1       = 3;
	localparam logic [3:0]  EMU_CTRL_RST  = 4'h0;
	// arbitrary identification value
	localparam logic [31:0] ID_VALUE      = 32'h00000001;

	// ********************************
	// gpio
	// ********************************
	localparam int          GPIO_W        = 8;
	localparam int          GPIO_BRANCH   = 1;

	// ********************************
	// pins
	// ********************************
	// idle levels the pad pulls give: second mode select low, every other sampled pin high
	localparam logic [7:0]  PIN_IDLE      = 8'hf7;

	// ********************************
	// timing
	// ********************************
	localparam int          REF_CLK_NS    = 100;
	localparam int          TCK_MIN_NS    = 800;
	localparam int          TCK_MIN_CYC   = TCK_MIN_NS / REF_CLK_NS;

endpackage

// ---- core/sctp_tap_fsm.sv ----
// boundary-scan tap state machine
`timescale 1ns/1ps
`default_nettype none

module sctp_tap_fsm
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// sampled test clock rising edge and mode selects
	input  wire logic tck_rise,
	input  wire logic tms,
	input  wire logic second_mode_select,
	// state decodes
	output logic      st_reset,
	output logic      st_capture_dr,
	output logic      st_shift_dr,
	output logic      st_update_dr,
	output logic      st_capture_ir,
	output logic      st_shift_ir,
	output logic      st_update_ir
);

	typedef enum logic [3:0]
	{
		TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
	} sctp_tap_e;

	sctp_tap_e state;
	sctp_tap_e next_state;
	logic      mode;

	// second select only matters for emulation; high on it forces test-logic-reset path
	assign mode = tms | second_mode_select;

	always_comb
	begin
		case (state)
			TLR:     next_state = mode ? TLR    : RTI;
			RTI:     next_state = mode ? SEL_DR : RTI;
			SEL_DR:  next_state = mode ? SEL_IR : CAP_DR;
			CAP_DR:  next_state = mode ? EX1_DR : SH_DR;
			SH_DR:   next_state = mode ? EX1_DR : SH_DR;
			EX1_DR:  next_state = mode ? UPD_DR : PA_DR;
			PA_DR:   next_state = mode ? EX2_DR : PA_DR;
			EX2_DR:  next_state = mode ? UPD_DR : SH_DR;
			UPD_DR:  next_state = mode ? SEL_DR : RTI;
			SEL_IR:  next_state = mode ? TLR    : CAP_IR;
			CAP_IR:  next_state = mode ? EX1_IR : SH_IR;
			SH_IR:   next_state = mode ? EX1_IR : SH_IR;
			EX1_IR:  next_state = mode ? UPD_IR : PA_IR;
			PA_IR:   next_state = mode ? EX2_IR : PA_IR;
			EX2_IR:  next_state = mode ? UPD_IR : SH_IR;
			UPD_IR:  next_state = mode ? SEL_DR : RTI;
			default: next_state = TLR;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			state <= TLR;
		else if (tck_rise)
			state <= next_state;
	end

	assign st_reset      = (state == TLR);
	assign st_capture_dr = (state == CAP_DR);
	assign st_shift_dr   = (state == SH_DR);
	assign st_update_dr  = (state == UPD_DR);
	assign st_capture_ir = (state == CAP_IR);
	assign st_shift_ir   = (state == SH_IR);
	assign st_update_ir  = (state == UPD_IR);

endmodule
`default_nettype wire

// ---- dv/sctp_top_properties.sv ----
// assertion checker for the scan port block
`timescale 1ns/1ps
`default_nettype none
module sctp_top_checker
#(
	parameter int GPIO_W = 8
)
(
	// clock and reset
	input wire logic              REF_CLK,
	input wire logic              SYS_RST,
	// pins
	input wire logic              TCK,
	input wire logic              TRST,
	input wire logic              EMULATOR_LINE_ZERO_IN,
	input wire logic              EMULATOR_LINE_ONE_OR_DISABLE_IN,
	input wire logic [GPIO_W-1:0] GPIO_IN,
	input wire logic              CONDITIONAL_BRANCH_OP,
	// outputs
	input wire logic              TDO,
	input wire logic              SCAN_CONTROL,
	input wire logic              ALL_OUTPUTS_OFF,
	input wire logic              EMULATOR_LINE_ONE_OR_DISABLE_OE,
	input wire logic              BRANCH_TAKEN,
	input wire logic              PORT_C_BIT_ONE_IS_GPIO,
	input wire logic [GPIO_W-1:0] GPIO_DIR
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);
	// ****
	// sequences
	// ****
	// four cycles cover the two-flop synchroniser plus the output register
	wire off_cond = !TRST && EMULATOR_LINE_ZERO_IN && !EMULATOR_LINE_ONE_OR_DISABLE_IN;
	sequence off_held; off_cond [*4]; endsequence
	sequence on_held; (!off_cond) [*4]; endsequence
	sequence poll_low;
		(!GPIO_IN[sctp_pkg::GPIO_BRANCH]) [*3] ##0 (CONDITIONAL_BRANCH_OP && !PORT_C_BIT_ONE_IS_GPIO);
	endsequence
	off_set_a: assert property (off_held |=> ALL_OUTPUTS_OFF) else $error("outputs not off");
	off_clear_a: assert property (on_held |=> !ALL_OUTPUTS_OFF) else $error("outputs off wrongly");
	scan_take_a: assert property (TRST [*3] |=> SCAN_CONTROL) else $error("no scan control");
	func_mode_a: assert property ((!TRST) [*3] |=> !SCAN_CONTROL) else $error("scan control stuck");
	func_line_a: assert property ((!TRST) [*3] |=> !EMULATOR_LINE_ONE_OR_DISABLE_OE) else $error("line driven");
	poll_take_a: assert property (poll_low |=> BRANCH_TAKEN) else $error("branch not taken");
	tdo_fall_a: assert property (TRST && $changed(TDO) |-> !$past(TCK, 3)) else $error("tdo off fall");
	port_reset_a: assert property ($fell(SYS_RST) |-> !(|GPIO_DIR) && !PORT_C_BIT_ONE_IS_GPIO) else $error("port not reset");
endmodule
bind sctp_top sctp_top_checker #(.GPIO_W(GPIO_W)) u_chk
(
	.REF_CLK, .SYS_RST, .TCK, .TRST, .EMULATOR_LINE_ZERO_IN, .EMULATOR_LINE_ONE_OR_DISABLE_IN, .GPIO_IN,
	.CONDITIONAL_BRANCH_OP, .TDO, .SCAN_CONTROL, .ALL_OUTPUTS_OFF, .EMULATOR_LINE_ONE_OR_DISABLE_OE,
	.BRANCH_TAKEN, .PORT_C_BIT_ONE_IS_GPIO, .GPIO_DIR
);
`default_nettype wire

// ---- dv/sctp_emu_model.sv ----
// scan emulator model: test clock, mode selects and data in
`timescale 1ns/1ps
`default_nettype none
module sctp_emu_model
(
	// test port pins
	output logic      tck,
	output logic      tms,
	output logic      second_mode_select,
	output logic      tdi,
	input  wire logic tdo
);
	// the test clock stands low between frames
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		second_mode_select = 1'b0;
		tdi = 1'b1;
	end
	// one 800 ns clock; tdo read mid high phase, where it stands until the fall
	task automatic tck_bit(input logic m, input logic m2, input logic d, output logic q);
		tms = m;
		second_mode_select = m2;
		tdi = d;
		#400;
		tck = 1'b1;
		#200;
		q = tdo;
		#200;
		tck = 1'b0;
	endtask
	task automatic walk(input logic [7:0] p, input int n);
		logic q;
		for (int i = 0; i < n; i++)
			tck_bit(p[i], 1'b0, 1'b1, q);
	endtask
	task automatic shift(input logic [31:0] din, input int n, output logic [31:0] dout);
		logic q;
		dout = 32'h0;
		for (int i = 0; i < n; i++)
		begin
			tck_bit(i == n - 1, 1'b0, din[i], q);
			dout[i] = q;
		end
	endtask
endmodule
`default_nettype wire

// ---- dv/sctp_top_tb_top.sv ----
// self-checking bench for the scan port block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module sctp_top_tb_top;
	typedef struct { int sel; logic [31:0] v; } sctp_note_s;
	logic        clk = 1'b0, rst = 1'b1, trst = 1'b0, d0 = 1'b1, v0 = 1'b1, d1 = 1'b1, v1 = 1'b1;
	logic        dwe = 1'b0, asg = 1'b0, swe = 1'b0, op = 1'b0, i0 = 1'b0, i1 = 1'b0;
	logic [7:0]  gin = 8'hff, dwr = 8'h00, gdir;
	logic        tck, tms, second_mode_select, tdi, tdo, toe, o0, e0, o1, e1, f0, f1, sc, off, isg, bt, q;
	logic [31:0] word;
	int          err_count = 0, checks = 0, seed = 79266;
	sctp_note_s  exp_q[$], n;
	// lines are pulled up; the emulator side drives only where the design lets go
	wire l0 = e0 ? o0 : (d0 ? v0 : 1'b1);
	wire l1 = e1 ? o1 : (d1 ? v1 : 1'b1);
	// the scan output pad is pulled down while the design lets go of it
	wire tdo_pin = toe ? tdo : 1'b0;
	initial forever #50 clk = ~clk;
	sctp_emu_model emu (.tck(tck), .tms(tms), .second_mode_select(second_mode_select), .tdi(tdi), .tdo(tdo_pin));
	sctp_top DUT
	(
		.REF_CLK(clk), .SYS_RST(rst), .TCK(tck), .TDI(tdi), .TMS(tms), .SECOND_MODE_SELECT(second_mode_select), .TRST(trst), .TDO(tdo),
		.TDO_OE(toe), .EMULATOR_LINE_ZERO_IN(l0), .EMULATOR_LINE_ZERO_OUT(o0), .EMULATOR_LINE_ZERO_OE(e0),
		.EMULATOR_LINE_ONE_OR_DISABLE_IN(l1), .EMULATOR_LINE_ONE_OR_DISABLE_OUT(o1),
		.EMULATOR_LINE_ONE_OR_DISABLE_OE(e1), .EMU_IRQ0_TO_EMU(i0), .EMU_IRQ1_TO_EMU(i1),
		.EMU_IRQ0_FROM_EMU(f0), .EMU_IRQ1_FROM_EMU(f1), .SCAN_CONTROL(sc), .ALL_OUTPUTS_OFF(off),
		.GPIO_IN(gin), .GPIO_DIR_WR(dwr), .GPIO_DIR_WE(dwe), .PORT_C_BIT_ONE_AS_GPIO(asg),
		.PORT_C_BIT_ONE_SEL_WE(swe), .GPIO_DIR(gdir), .PORT_C_BIT_ONE_IS_GPIO(isg),
		.CONDITIONAL_BRANCH_OP(op), .BRANCH_TAKEN(bt)
	);
	// ****
	// helpers
	// ****
	function automatic logic [31:0] obs(input int s);
		case (s)
			0: obs = {31'h0, off};
			1: obs = {31'h0, sc};
			2: obs = {31'h0, bt};
			3: obs = word;
			4: obs = {31'h0, f0};
			5: obs = {24'h0, gdir};
			6: obs = {31'h0, isg};
			8: obs = {28'h0, toe, f1, e0, o0};
			default: obs = {30'h0, e1, o1};
		endcase
	endfunction
	task automatic note(input int s, input logic [31:0] v);
		exp_q.push_back('{s, v});
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#10;
	endtask
	// the pin is held three cycles so the synchroniser has settled
	task automatic poll(input logic [7:0] p, input logic m);
		gin = p;
		step(3);
		op = 1'b1;
		step(1);
		op = 1'b0;
		note(2, {31'h0, m && !p[1]});
	endtask
	task automatic do_reset();
		rst = 1'b1;
		step(2);
		rst = 1'b0;
		step(4);
		note(5, 32'h0);
		note(6, 32'h0);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(negedge clk)
		while (exp_q.size() > 0)
		begin
			n = exp_q.pop_front();
			`CHK(obs(n.sel), n.v)
		end
	// ****
	// tests
	// ****
	initial
	begin
		do_reset();
		$display("reset done");
		for (int i = 0; i < 8; i++)
		begin
			{trst, v0, v1} = i[2:0];
			step(5);
			note(0, {31'h0, !trst && v0 && !v1});
		end
		$display("output-off done");
		trst = 1'b0;
		for (int i = 0; i < 12; i++)
			poll(8'($random(seed)), 1'b1);
		dwr = 8'($random(seed)) | 8'h01;
		{asg, swe, dwe} = 3'h7;
		step(1);
		{swe, dwe} = 2'h0;
		note(6, 32'h1);
		note(5, {24'h0, dwr});
		poll(8'h00, 1'b0);
		do_reset();
		poll(8'h00, 1'b1);
		$display("branch poll done");
		{trst, d0, d1} = 3'h4;
		step(4);
		note(1, 32'h1);
		emu.walk(8'h06, 5);
		// the second select alone walks the port from shift-ir back to reset
		repeat (5) emu.tck_bit(1'b0, 1'b1, 1'b1, q);
		emu.walk(8'h02, 4);
		// test clock stands low while the shift-dr output enable is checked
		i1 = 1'b1;
		step(4);
		note(8, 32'hc);
		note(7, 32'h1);
		i1 = 1'b0;
		emu.shift(32'h0, 32, word);
		note(3, sctp_pkg::ID_VALUE);
		emu.walk(8'h07, 5);
		emu.shift({28'h0, sctp_pkg::IR_EMU_CTRL}, 4, word);
		note(3, {28'h0, sctp_pkg::IR_CAPTURE});
		emu.walk(8'h03, 4);
		emu.shift(32'h1 << sctp_pkg::EC_OE1 | 32'h1 << sctp_pkg::EC_OUT1, 4, word);
		emu.walk(8'h01, 2);
		step(4);
		note(7, 32'h3);
		i0 = 1'b1;
		step(4);
		note(8, 32'h1);
		i0 = 1'b0;
		{d0, v0} = 2'h3;
		step(4);
		note(4, 32'h1);
		v0 = 1'b0;
		step(4);
		note(4, 32'h0);
		trst = 1'b0;
		step(4);
		note(1, 32'h0);
		$display("scan port done");
		step(2);
		tally_and_finish();
	end
	initial
	begin
		#500000;
		err_count++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
